// ==== rtl/prot_pkg.sv ====
// Purpose: Shared constants for the converter protection manager
// Assumes: 200 MHz controller clock, byte-wide register port
// Notes:   Fault vectors are indexed F_OV..F_TR, matching config bits 1..5
package prot_pkg;

  // Register port geometry
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 8;

  // Register offsets
  localparam logic [7:0] REG_FLAGS = 8'h00;
  localparam logic [7:0] REG_PTYPE = 8'h04;
  localparam logic [7:0] REG_PROP  = 8'h08;
  localparam logic [7:0] REG_CLIM  = 8'h0C;
  localparam logic [7:0] REG_LEVEL = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'hFF;
  localparam logic [7:0] PTYPE_RST = 8'h43;
  localparam logic [7:0] PROP_RST  = 8'h3F;
  localparam logic [7:0] CLIM_RST  = 8'h10;
  localparam logic [7:0] LEVEL_RST = 8'h08;

  // Field positions
  localparam int BIT_HOT  = 7;
  localparam int BIT_WIN  = 6;
  localparam int BIT_PHV  = 0;
  localparam int BIT_TRE  = 7;
  localparam int BIT_PTM  = 7;
  localparam int BIT_PGM  = 6;
  localparam int BIT_TCE  = 4;
  localparam int BIT_PGLL = 4;
  localparam int OVPL_LO  = 2;
  localparam int OVPL_HI  = 3;
  localparam int CLS_HI   = 3;
  localparam int FLT_LO   = 1;
  localparam int FLT_HI   = 5;

  // Fault index inside the fault vectors
  localparam int F_OV = 0;
  localparam int F_UV = 1;
  localparam int F_OC = 2;
  localparam int F_OT = 3;
  localparam int F_TR = 4;
  localparam int NFLT = 5;

  // Comparator set points, for reference by the analog front end
  localparam int TEMP_WARN_SET_C   = 120;
  localparam int TEMP_WARN_CLR_C   = 117;
  localparam int TEMP_RESTART_C    = 110;
  localparam int TRACK_LIMIT_MV    = 250;
  localparam int OV_FLOOR_MV       = 1000;

  // Hiccup interval
  localparam int CLK_MHZ    = 200;
  localparam int HICCUP_MS  = 130;
  localparam int HICCUP_CYC = HICCUP_MS * CLK_MHZ * 1000;

  // Power stage sequencer states
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_SHUT, ST_WAIT} pwr_state_t;

endpackage : prot_pkg

// ==== rtl/hiccup_timer.sv ====
// Purpose: Restart interval timer for the protection manager
// Assumes: i_start is a one-cycle pulse
// Notes:   o_done stays high from expiry until the next start
`timescale 1ns/1ps
`default_nettype none
module hiccup_timer #(
  parameter int CYCLES = 26000000
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  output var  logic o_busy,
  output var  logic o_done
);

  localparam int CW = $clog2(CYCLES + 1);

  // Refuse an interval the counter cannot hold
  if (CYCLES < 1) begin : g_chk
    $error("hiccup_timer: CYCLES must be at least one");
  end

  logic [CW-1:0] cnt_q;
  wire           last_w = (cnt_q == CW'(1));

  // Count down from the interval; done flags the end of the wait
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_start) begin
      cnt_q  <= CW'(CYCLES);
      o_busy <= 1'b1;
      o_done <= 1'b0;
    end else if (o_busy) begin
      cnt_q  <= cnt_q - CW'(1);
      o_busy <= !last_w;
      o_done <= last_w;
    end
  end

endmodule : hiccup_timer
`default_nettype wire

// ==== rtl/prot_manager.sv ====
// Purpose: Protection and fault manager of a step-down load converter
// Assumes: Comparator and state inputs are synchronous to I_CLK;
//          power-good pin and turn-on command are asynchronous
// Notes:   Health flags are active low; writing 1 to a fault flag restores it only if its condition is already gone
//
// Contract
// - Warnings only report, never stop output
// - Above 120C set hot flag low, notify
// - Hot warning notified only if enabled
// - Hot warning removed below 117C
// - Power-good low outside 110% / 90-95% window
// - Power-good armed only in steady state
// - Window warning: pin low, flag low, notify
// - Back in window: release pin, restore flag
// - External low on pin raises window warning
// - Any fault class event shuts converter down
// - Overcurrent watched only above pre-bias
// - Overcurrent fault: flag low, fast off
// - Current limit temperature compensation is selectable
// - Undervoltage in steady state, no overcurrent
// - Over-temperature fault above 120C, sequenced off
// - Non-latching over-temperature restarts below 110C
// - Tracking checked only while ramping up
// - Tracking beyond 250mV: flag low, fast off
// - Tracking protection can be disabled
// - Overvoltage: flag low, high off, low on
// - Overvoltage level 110-130%, floor 1.0V
// - Phase voltage error not implemented
// - Local fault may shut other converters
// - Non-latching retries every 130ms
// - Latching waits 130ms, clear and recycle; here either one alone allows the restart
// - Propagated fault pulls group line low
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module prot_manager #(
  parameter int HICCUP_CYCLES = prot_pkg::HICCUP_CYC
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // Register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output var  logic [7:0]  O_RDATA,
  // Comparator and converter state inputs
  input  wire logic        I_TEMP_ABOVE_SET,
  input  wire logic        I_TEMP_BELOW_CLR,
  input  wire logic        I_TEMP_BELOW_RESTART,
  input  wire logic        I_VO_ABOVE_PG_HIGH,
  input  wire logic        I_VO_BELOW_PG_LOW,
  input  wire logic        I_VO_ABOVE_PREBIAS,
  input  wire logic        I_VO_BELOW_UV,
  input  wire logic        I_VO_ABOVE_OV,
  input  wire logic        I_CURRENT_LIMIT,
  input  wire logic        I_TRACK_EXCEEDED,
  input  wire logic        I_STEADY,
  input  wire logic        I_RAMP_UP,
  input  wire logic        I_VO_ZERO,
  input  wire logic        I_TURN_ON,
  // Open-drain power-good pin
  input  wire logic        I_PG_IN,
  output var  logic        O_PG_OUT,
  output var  logic        O_PG_OE_N,
  // Open-drain group fault line
  output var  logic        O_GRP_OUT,
  output var  logic        O_GRP_OE_N,
  // Power stage commands
  output var  logic        O_RUN,
  output var  logic        O_SEQ_OFF,
  output var  logic        O_FAST_OFF,
  output var  logic        O_LOW_SIDE_ON,
  // Threshold settings for the analog front end
  output var  logic        O_PG_LOW_SEL,
  output var  logic [1:0]  O_OV_LEVEL,
  output var  logic        O_TEMP_COMP_EN,
  output var  logic [3:0]  O_CL_SET,
  // Notice to the system power manager
  output var  logic        O_NOTIFY
);

  localparam int NF = prot_pkg::NFLT;

  // Refuse an interval the sequencer cannot serve
  if (HICCUP_CYCLES < 1) begin : g_chk
    $error("prot_manager: HICCUP_CYCLES must be at least one");
  end

  // Configuration registers
  logic [7:0]  ptype_q;
  logic [7:0]  prop_q;
  logic [7:0]  clim_q;
  logic [7:0]  level_q;

  // Status and sequencer state
  logic [NF-1:0] fault_q;
  logic [NF-1:0] fault_d;
  logic [NF-1:0] cause_q;
  logic [NF-1:0] cause_d;
  logic          hot_q;
  logic          hot_d;
  logic          armed_q;
  logic [1:0]    rel_q;
  logic          recyc_q;
  logic          recyc_d;
  prot_pkg::pwr_state_t st_q;
  prot_pkg::pwr_state_t st_d;

  // Synchronisers for asynchronous pins
  logic [1:0]  pg_sync_q;
  logic [1:0]  on_sync_q;

  // Timer handshake
  logic        tmr_start;
  logic        tmr_busy;
  logic        tmr_done;

  // Two flip-flops ahead of any use of the pins
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pg_sync_q <= 2'h3;
      on_sync_q <= 2'h0;
    end else begin
      pg_sync_q <= {pg_sync_q[0], I_PG_IN};
      on_sync_q <= {on_sync_q[0], I_TURN_ON};
    end
  end

  wire pg_pin_s = pg_sync_q[1];
  wire turn_on_s = on_sync_q[1];

  // Address decode
  wire sel_flags = (I_ADDR == prot_pkg::REG_FLAGS);
  wire sel_ptype = (I_ADDR == prot_pkg::REG_PTYPE);
  wire sel_prop  = (I_ADDR == prot_pkg::REG_PROP);
  wire sel_clim  = (I_ADDR == prot_pkg::REG_CLIM);
  wire sel_level = (I_ADDR == prot_pkg::REG_LEVEL);
  wire sel_state = (I_ADDR == prot_pkg::REG_STATE);
  wire wr_flags  = I_WR && sel_flags;

  // Fault-related fields taken from the configuration registers
  wire [NF-1:0] latch_cfg = ptype_q[prot_pkg::FLT_HI:prot_pkg::FLT_LO];
  wire [NF-1:0] prop_cfg  = prop_q[prot_pkg::FLT_HI:prot_pkg::FLT_LO];
  wire [NF-1:0] flag_wr   = wr_flags ? I_WDATA[prot_pkg::FLT_HI:prot_pkg::FLT_LO]
                                     : '0;
  wire          track_en  = ptype_q[prot_pkg::BIT_TRE];

  // Configuration writes; reserved bits of the level register stay zero
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ptype_q <= prot_pkg::PTYPE_RST;
      prop_q  <= prot_pkg::PROP_RST;
      clim_q  <= prot_pkg::CLIM_RST;
      level_q <= prot_pkg::LEVEL_RST;
    end else if (I_WR) begin
      if (sel_ptype) ptype_q <= I_WDATA;
      if (sel_prop)  prop_q  <= I_WDATA;
      if (sel_clim)  clim_q  <= I_WDATA;
      if (sel_level) level_q <= {3'h0, I_WDATA[4:0]};
    end
  end

  // Over-temperature warning with hysteresis
  assign hot_d = I_TEMP_ABOVE_SET ? 1'b1
               : I_TEMP_BELOW_CLR ? 1'b0
               : hot_q;

  // Power-good window check once armed; outside drive seen only once the
  // synchroniser shows the released wire, so our own release is no false low
  wire pg_out_win = I_VO_ABOVE_PG_HIGH || I_VO_BELOW_PG_LOW;
  wire pg_ext_low = O_PG_OE_N && rel_q[1] && !pg_pin_s;
  wire pg_warn    = armed_q && (pg_out_win || pg_ext_low);
  // An outside low already holds the wire; driving it would hide its end
  wire pg_drive_d = !armed_q || pg_out_win || !I_STEADY;

  // Warnings arm and track; none of them reach the power stage
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      hot_q   <= 1'b0;
      armed_q <= 1'b0;
      rel_q   <= 2'h0;
    end else begin
      hot_q   <= hot_d;
      rel_q   <= {rel_q[0], O_PG_OE_N};
      armed_q <= I_STEADY && st_q == prot_pkg::ST_RUN;
    end
  end

  // Fault detection for the running converter
  wire running = (st_q == prot_pkg::ST_RUN);
  logic [NF-1:0] trip;
  assign trip[prot_pkg::F_OC] = running && I_VO_ABOVE_PREBIAS
                             && I_CURRENT_LIMIT && I_VO_BELOW_UV;
  assign trip[prot_pkg::F_UV] = running && I_STEADY && I_VO_BELOW_UV
                             && !trip[prot_pkg::F_OC];
  assign trip[prot_pkg::F_OT] = running && I_TEMP_ABOVE_SET;
  assign trip[prot_pkg::F_TR] = running && I_RAMP_UP && track_en
                             && I_TRACK_EXCEEDED;
  assign trip[prot_pkg::F_OV] = running && I_VO_ABOVE_PREBIAS
                             && I_VO_ABOVE_OV;
  wire any_trip = |trip;

  // Conditions that still hold, used to gate a latched restart
  logic [NF-1:0] cond;
  assign cond[prot_pkg::F_OC] = I_CURRENT_LIMIT;
  assign cond[prot_pkg::F_UV] = I_VO_BELOW_UV && I_STEADY;
  assign cond[prot_pkg::F_OT] = !I_TEMP_BELOW_RESTART;
  assign cond[prot_pkg::F_TR] = 1'b0;
  assign cond[prot_pkg::F_OV] = I_VO_ABOVE_OV;

  // Restart gating once the interval has run out
  wire [NF-1:0] lat_cause   = cause_q & latch_cfg;
  wire [NF-1:0] nlat_cause  = cause_q & ~latch_cfg;
  wire          lat_ok      = ((lat_cause & (cond | fault_q)) == '0)
                            || (recyc_q && (lat_cause & cond) == '0);
  wire          ot_wait     = nlat_cause[prot_pkg::F_OT]
                            && !I_TEMP_BELOW_RESTART;
  wire          may_restart = tmr_done && lat_ok && !ot_wait;
  wire          restart     = (st_q == prot_pkg::ST_WAIT) && may_restart
                            && turn_on_s;

  // Per-fault flag: trip sets it, write of 1 with its condition gone or a restart of a non-latched fault restores it
  for (genvar i = 0; i < NF; i++) begin : g_flag
    wire clr = (flag_wr[i] && !cond[i])
            || (restart && !latch_cfg[i]);
    assign fault_d[i] = trip[i] || (fault_q[i] && !clr);
  end

  // Sequencer next state
  always_comb begin
    st_d      = st_q;
    cause_d   = cause_q;
    recyc_d   = recyc_q;
    tmr_start = 1'b0;
    case (st_q)
      prot_pkg::ST_OFF: begin
        if (turn_on_s && !tmr_busy) begin
          st_d    = prot_pkg::ST_RUN;
          cause_d = '0;
          recyc_d = 1'b0;
        end
      end
      prot_pkg::ST_RUN: begin
        if (any_trip) begin
          st_d    = prot_pkg::ST_SHUT;
          cause_d = trip;
        end else if (!turn_on_s) begin
          st_d    = prot_pkg::ST_OFF;
        end
      end
      prot_pkg::ST_SHUT: begin
        if (I_VO_ZERO) begin
          st_d      = prot_pkg::ST_WAIT;
          tmr_start = 1'b1;
        end
      end
      prot_pkg::ST_WAIT: begin
        if (!turn_on_s) begin
          recyc_d = 1'b1;
        end
        if (restart) begin
          st_d    = prot_pkg::ST_RUN;
          cause_d = '0;
          recyc_d = 1'b0;
        end
      end
      default: st_d = prot_pkg::ST_OFF;
    endcase
  end

  // Shutdown style chosen from the cause of the trip
  wire [NF-1:0] sd_cause = (st_d == prot_pkg::ST_SHUT) ? cause_d : '0;
  wire          crow_d   = sd_cause[prot_pkg::F_OV];
  wire          fast_d   = crow_d || sd_cause[prot_pkg::F_OC]
                        || sd_cause[prot_pkg::F_TR];
  wire          seq_d    = (st_d != prot_pkg::ST_RUN) && !fast_d;
  wire          run_d    = (st_d == prot_pkg::ST_RUN);

  // Group line low while a propagated fault is standing
  wire grp_low_d = |(fault_d & prop_cfg);

  // Notice to the manager: enabled warnings and any standing fault
  wire notify_d = (hot_d && prop_q[prot_pkg::BIT_PTM])
               || (pg_warn && prop_q[prot_pkg::BIT_PGM])
               || (|fault_d);

  // Sequencer and fault registers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_q    <= prot_pkg::ST_OFF;
      cause_q <= '0;
      fault_q <= '0;
      recyc_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cause_q <= cause_d;
      fault_q <= fault_d;
      recyc_q <= recyc_d;
    end
  end

  // Restart interval
  hiccup_timer #(
    .CYCLES (HICCUP_CYCLES)
  ) u_hiccup (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_start (tmr_start),
    .o_busy  (tmr_busy),
    .o_done  (tmr_done)
  );

  // Health flags, active low; the phase voltage bit never drops
  wire [7:0] flags_w = {!hot_q,
                        !(armed_q ? (pg_out_win || pg_ext_low) : 1'b0),
                        ~fault_q,
                        1'b1};

  // Read multiplexer; unmapped addresses read zero
  wire [7:0] rd_mux = sel_flags ? flags_w
                    : sel_ptype ? ptype_q
                    : sel_prop  ? prop_q
                    : sel_clim  ? clim_q
                    : sel_level ? level_q
                    : sel_state ? {6'h00, st_q}
                    : 8'h00;

  // Registered outputs
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA        <= 8'h00;
      O_PG_OUT       <= 1'b0;
      O_PG_OE_N      <= 1'b0;
      O_GRP_OUT      <= 1'b0;
      O_GRP_OE_N     <= 1'b1;
      O_RUN          <= 1'b0;
      O_SEQ_OFF      <= 1'b1;
      O_FAST_OFF     <= 1'b0;
      O_LOW_SIDE_ON  <= 1'b0;
      O_PG_LOW_SEL   <= 1'b0;
      O_OV_LEVEL     <= 2'h0;
      O_TEMP_COMP_EN <= 1'b0;
      O_CL_SET       <= 4'h0;
      O_NOTIFY       <= 1'b0;
    end else begin
      O_RDATA        <= I_RD ? rd_mux : 8'h00;
      O_PG_OUT       <= 1'b0;
      O_PG_OE_N      <= !pg_drive_d;
      O_GRP_OUT      <= 1'b0;
      O_GRP_OE_N     <= !grp_low_d;
      O_RUN          <= run_d;
      O_SEQ_OFF      <= seq_d;
      O_FAST_OFF     <= fast_d;
      O_LOW_SIDE_ON  <= crow_d;
      O_PG_LOW_SEL   <= level_q[prot_pkg::BIT_PGLL];
      O_OV_LEVEL     <= level_q[prot_pkg::OVPL_HI:prot_pkg::OVPL_LO];
      O_TEMP_COMP_EN <= clim_q[prot_pkg::BIT_TCE];
      O_CL_SET       <= clim_q[prot_pkg::CLS_HI:0];
      O_NOTIFY       <= notify_d;
    end
  end

endmodule : prot_manager
`default_nettype wire

// ==== testbench/prot_manager_assertions.sv ====
// Purpose: Port checker for the protection manager
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to every prot_manager instance after the module
`timescale 1ns/1ps
`default_nettype none
module prot_manager_chk (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CURRENT_LIMIT,
  input wire logic I_VO_BELOW_UV,
  input wire logic I_VO_ABOVE_PREBIAS,
  input wire logic I_VO_ABOVE_OV,
  input wire logic I_TRACK_EXCEEDED,
  input wire logic I_STEADY,
  input wire logic I_VO_ABOVE_PG_HIGH,
  input wire logic I_VO_BELOW_PG_LOW,
  input wire logic O_RUN,
  input wire logic O_FAST_OFF,
  input wire logic O_LOW_SIDE_ON,
  input wire logic O_PG_OE_N,
  input wire logic O_PG_OUT,
  input wire logic O_GRP_OUT
);
  // All checks share the controller clock
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  // Trips act one clock after the sampled cause
  property p_oc_fast;
    O_RUN && I_CURRENT_LIMIT && I_VO_BELOW_UV && I_VO_ABOVE_PREBIAS |=> O_FAST_OFF && !O_RUN;
  endproperty
  a_oc_fast: assert property (p_oc_fast) else $error("overcurrent trip missed");
  property p_ov_low;
    O_RUN && I_VO_ABOVE_OV && I_VO_ABOVE_PREBIAS |=> O_FAST_OFF && O_LOW_SIDE_ON;
  endproperty
  a_ov_low: assert property (p_ov_low) else $error("overvoltage trip missed");
  property p_uv_off;
    O_RUN && I_STEADY && I_VO_BELOW_UV |=> !O_RUN;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("low output trip missed");
  property p_fast_cause;
    $rose(O_FAST_OFF) |-> $past(I_VO_ABOVE_OV || I_CURRENT_LIMIT || I_TRACK_EXCEEDED);
  endproperty
  a_fast_cause: assert property (p_fast_cause) else $error("fast off without cause");
  property p_low_fast;
    O_LOW_SIDE_ON |-> O_FAST_OFF && !O_RUN;
  endproperty
  a_low_fast: assert property (p_low_fast) else $error("low side on while running");
  // Power-good pin is pulled while unarmed or outside the window
  property p_pg_unarmed;
    !I_STEADY [*3] |-> !O_PG_OE_N;
  endproperty
  a_pg_unarmed: assert property (p_pg_unarmed) else $error("pg released unarmed");
  property p_pg_window;
    (I_VO_ABOVE_PG_HIGH || I_VO_BELOW_PG_LOW) [*3] |-> !O_PG_OE_N;
  endproperty
  a_pg_window: assert property (p_pg_window) else $error("pg released outside window");
  property p_od_drive;
    !O_PG_OUT && !O_GRP_OUT;
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open-drain pin driven high");
endmodule : prot_manager_chk
bind prot_manager prot_manager_chk i_chk (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_CURRENT_LIMIT(I_CURRENT_LIMIT),
  .I_VO_BELOW_UV(I_VO_BELOW_UV), .I_VO_ABOVE_PREBIAS(I_VO_ABOVE_PREBIAS),
  .I_VO_ABOVE_OV(I_VO_ABOVE_OV), .I_TRACK_EXCEEDED(I_TRACK_EXCEEDED), .I_STEADY(I_STEADY),
  .I_VO_ABOVE_PG_HIGH(I_VO_ABOVE_PG_HIGH), .I_VO_BELOW_PG_LOW(I_VO_BELOW_PG_LOW),
  .O_RUN(O_RUN), .O_FAST_OFF(O_FAST_OFF), .O_LOW_SIDE_ON(O_LOW_SIDE_ON),
  .O_PG_OE_N(O_PG_OE_N), .O_PG_OUT(O_PG_OUT), .O_GRP_OUT(O_GRP_OUT));
`default_nettype wire

// ==== testbench/pg_line_model.sv ====
// Purpose: Power-good wire with pull-up and an outside pull-down
// Assumes: Enable low means the device pulls the wire low
// Notes:   A released wire reads the pull-up level, never a stale value
`timescale 1ns/1ps
`default_nettype none
module pg_line_model (
  input  wire logic i_oe_n,
  input  wire logic i_ext_low,
  output var  logic o_level
);
  // Wired-AND of both pull-downs over the pull-up
  assign o_level = i_oe_n & ~i_ext_low;
endmodule : pg_line_model
`default_nettype wire

// ==== testbench/test_converter_protection_manager.sv ====
// Purpose: Self-checking bench for the protection manager
// Assumes: Shortened restart interval, pull-up on the power-good wire
// Notes:   Expected values come from the bench's own tables and constants
`timescale 1ns/1ps
`default_nettype none
module test_converter_protection_manager;
  localparam int HC = 20;
  // Fault table by fault index: fast off, low side on, held off after timer
  localparam logic [4:0] FAST_K = 5'b10101;
  localparam logic [4:0] LOW_K  = 5'b00001;
  localparam logic [4:0] HOLD_K = 5'b01001;
  logic       I_CLK, I_RST, I_WR, I_RD, I_PG_IN, ext_low, I_TURN_ON, I_VO_ZERO;
  logic [7:0] I_ADDR, I_WDATA, O_RDATA, rv, seed;
  logic       I_TEMP_ABOVE_SET, I_TEMP_BELOW_CLR, I_TEMP_BELOW_RESTART, I_VO_ABOVE_PG_HIGH;
  logic       I_VO_BELOW_PG_LOW, I_VO_ABOVE_PREBIAS, I_VO_BELOW_UV, I_VO_ABOVE_OV;
  logic       I_CURRENT_LIMIT, I_TRACK_EXCEEDED, I_STEADY, I_RAMP_UP, O_PG_OUT, O_PG_OE_N;
  logic       O_GRP_OUT, O_GRP_OE_N, O_RUN, O_SEQ_OFF, O_FAST_OFF, O_LOW_SIDE_ON;
  logic       O_PG_LOW_SEL, O_TEMP_COMP_EN, O_NOTIFY;
  logic [1:0] O_OV_LEVEL;
  logic [3:0] O_CL_SET;
  int         error_cnt, n_tests, n;
  logic [7:0] ra [6] = '{prot_pkg::REG_FLAGS, prot_pkg::REG_PTYPE, prot_pkg::REG_PROP,
                         prot_pkg::REG_CLIM, prot_pkg::REG_LEVEL, 8'hFC};
  logic [7:0] rr [6] = '{8'hFF, 8'h43, 8'h3F, 8'h10, 8'h08, 8'h00};

  prot_manager #(.HICCUP_CYCLES(HC)) i_dut (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_TEMP_ABOVE_SET(I_TEMP_ABOVE_SET),
    .I_TEMP_BELOW_CLR(I_TEMP_BELOW_CLR), .I_TEMP_BELOW_RESTART(I_TEMP_BELOW_RESTART),
    .I_VO_ABOVE_PG_HIGH(I_VO_ABOVE_PG_HIGH), .I_VO_BELOW_PG_LOW(I_VO_BELOW_PG_LOW),
    .I_VO_ABOVE_PREBIAS(I_VO_ABOVE_PREBIAS), .I_VO_BELOW_UV(I_VO_BELOW_UV),
    .I_VO_ABOVE_OV(I_VO_ABOVE_OV), .I_CURRENT_LIMIT(I_CURRENT_LIMIT),
    .I_TRACK_EXCEEDED(I_TRACK_EXCEEDED), .I_STEADY(I_STEADY), .I_RAMP_UP(I_RAMP_UP),
    .I_VO_ZERO(I_VO_ZERO), .I_TURN_ON(I_TURN_ON), .I_PG_IN(I_PG_IN), .O_PG_OUT(O_PG_OUT),
    .O_PG_OE_N(O_PG_OE_N), .O_GRP_OUT(O_GRP_OUT), .O_GRP_OE_N(O_GRP_OE_N), .O_RUN(O_RUN),
    .O_SEQ_OFF(O_SEQ_OFF), .O_FAST_OFF(O_FAST_OFF), .O_LOW_SIDE_ON(O_LOW_SIDE_ON),
    .O_PG_LOW_SEL(O_PG_LOW_SEL), .O_OV_LEVEL(O_OV_LEVEL), .O_TEMP_COMP_EN(O_TEMP_COMP_EN),
    .O_CL_SET(O_CL_SET), .O_NOTIFY(O_NOTIFY));
  pg_line_model i_pg (.i_oe_n(O_PG_OE_N), .i_ext_low(ext_low), .o_level(I_PG_IN));

  // 200 MHz clock and a run-length guard
  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int c);
    repeat (c) @(posedge I_CLK);
    #1;
  endtask : step
  // Bus cycles: one strobe cycle each, strobes cleared by idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    I_WR <= 1'b1;
    I_RD <= 1'b0;
    I_ADDR <= a;
    I_WDATA <= d;
    step(1);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, m, e);
    I_RD <= 1'b1;
    I_WR <= 1'b0;
    I_ADDR <= a;
    step(1);
    chk(nm, O_RDATA & m, e);
  endtask : rchk
  task automatic idle();
    I_WR <= 1'b0;
    I_RD <= 1'b0;
  endtask : idle
  task automatic wait_run(input int b);
    n = 0;
    while (O_RUN !== 1'b1 && n < b) begin
      step(1);
      n++;
    end
    if (n >= b) begin
      chk("run timeout", 8'h00, 8'h01);
      stop_test();
    end
  endtask : wait_run
  // Raise or clear the comparator inputs of one fault kind
  task automatic drive(input int k, input logic v);
    case (k)
      prot_pkg::F_OV: I_VO_ABOVE_OV <= v;
      prot_pkg::F_UV: I_VO_BELOW_UV <= v;
      prot_pkg::F_OC: begin
        I_CURRENT_LIMIT <= v;
        I_VO_BELOW_UV <= v;
      end
      prot_pkg::F_OT: begin
        I_TEMP_ABOVE_SET <= v;
        I_TEMP_BELOW_CLR <= ~v;
      end
      default: begin
        I_TRACK_EXCEEDED <= v;
        I_RAMP_UP <= v;
        I_STEADY <= ~v;
      end
    endcase
  endtask : drive

  // Main sequence
  initial begin
    {I_WR, I_RD, I_ADDR, I_WDATA, ext_low, I_TURN_ON, I_VO_ZERO, I_TEMP_ABOVE_SET} = '0;
    {I_VO_ABOVE_PG_HIGH, I_VO_BELOW_PG_LOW, I_VO_BELOW_UV, I_VO_ABOVE_OV} = '0;
    {I_CURRENT_LIMIT, I_TRACK_EXCEEDED, I_STEADY, I_RAMP_UP} = '0;
    {I_RST, I_TEMP_BELOW_CLR, I_TEMP_BELOW_RESTART, I_VO_ABOVE_PREBIAS} = '1;
    seed = 8'h55;
    repeat (16) @(posedge I_CLK);
    I_RST <= 1'b0;
    step(1);
    for (int i = 0; i < 6; i++) rchk("reset value", ra[i], 8'hFF, rr[i]);
    chk("ov level", O_OV_LEVEL, 8'h02);
    chk("temp comp", O_TEMP_COMP_EN, 8'h01);
    chk("pg pin", O_PG_OE_N, 8'h00);
    wr(prot_pkg::REG_LEVEL, 8'hFF);
    wr(8'hFC, 8'hFF);
    rchk("level cfg", prot_pkg::REG_LEVEL, 8'hFF, 8'h1F);
    rchk("unmapped", 8'hFC, 8'hFF, 8'h00);
    chk("ov level", O_OV_LEVEL, 8'h03);
    chk("pg low select", O_PG_LOW_SEL, 8'h01);
    wr(prot_pkg::REG_LEVEL, 8'h08);
    repeat (4) begin
      seed = lfsr(seed);
      rv = seed & 8'h1A;
      wr(prot_pkg::REG_CLIM, rv);
      rchk("limit cfg", prot_pkg::REG_CLIM, 8'hFF, rv);
      chk("temp comp", O_TEMP_COMP_EN, rv[4]);
      chk("limit", O_CL_SET, rv[3:0]);
    end
    wr(prot_pkg::REG_PROP, 8'hBF);
    idle();
    drive(prot_pkg::F_OT, 1'b1);
    step(2);
    chk("notify", O_NOTIFY, 8'h01);
    rchk("hot flag", prot_pkg::REG_FLAGS, 8'h80, 8'h00);
    wr(prot_pkg::REG_PROP, 8'h3F);
    idle();
    I_TEMP_ABOVE_SET <= 1'b0;
    step(2);
    chk("notify", O_NOTIFY, 8'h00);
    rchk("hot flag", prot_pkg::REG_FLAGS, 8'h80, 8'h00);
    idle();
    I_TEMP_BELOW_CLR <= 1'b1;
    step(2);
    rchk("hot flag", prot_pkg::REG_FLAGS, 8'h80, 8'h80);
    idle();
    I_TURN_ON <= 1'b1;
    I_STEADY <= 1'b1;
    wait_run(8);
    wr(prot_pkg::REG_PROP, 8'h7F);
    idle();
    step(6);
    chk("pg pin", O_PG_OE_N, 8'h01);
    I_VO_BELOW_PG_LOW <= 1'b1;
    step(2);
    chk("pg pin", O_PG_OE_N, 8'h00);
    chk("notify", O_NOTIFY, 8'h01);
    chk("run", O_RUN, 8'h01);
    rchk("window flag", prot_pkg::REG_FLAGS, 8'h40, 8'h00);
    idle();
    I_VO_BELOW_PG_LOW <= 1'b0;
    step(3);
    chk("pg pin", O_PG_OE_N, 8'h01);
    rchk("window flag", prot_pkg::REG_FLAGS, 8'h40, 8'h40);
    idle();
    ext_low <= 1'b1;
    step(5);
    chk("notify", O_NOTIFY, 8'h01);
    rchk("window flag", prot_pkg::REG_FLAGS, 8'h40, 8'h00);
    idle();
    ext_low <= 1'b0;
    step(6);
    // Tracking ignored when disabled, and when not ramping
    for (int j = 0; j < 2; j++) begin
      wr(prot_pkg::REG_PTYPE, j ? 8'hC3 : 8'h43);
      idle();
      I_TRACK_EXCEEDED <= 1'b1;
      I_RAMP_UP <= (j == 0);
      I_STEADY <= (j == 1);
      step(3);
      chk("run", O_RUN, 8'h01);
      drive(prot_pkg::F_TR, 1'b0);
      step(6);
    end
    // Every fault kind: trip, shutdown style, restart gap or hold
    for (int k = 0; k < prot_pkg::NFLT; k++) begin
      I_TEMP_BELOW_RESTART <= (k != prot_pkg::F_OT);
      drive(k, 1'b1);
      step(2);
      chk("fast off", O_FAST_OFF, FAST_K[k]);
      chk("low side", O_LOW_SIDE_ON, LOW_K[k]);
      chk("seq off", O_SEQ_OFF, !FAST_K[k]);
      chk("run", O_RUN, 8'h00);
      chk("notify", O_NOTIFY, 8'h01);
      chk("group line", O_GRP_OE_N, 8'h00);
      rchk("fault flags", prot_pkg::REG_FLAGS, 8'h3E, 8'h3E ^ (8'h02 << k));
      idle();
      drive(k, 1'b0);
      I_VO_ZERO <= 1'b1;
      if (HOLD_K[k]) begin
        step(HC + 8);
        chk("held off", O_RUN, 8'h00);
        if (k == prot_pkg::F_OV) wr(prot_pkg::REG_FLAGS, 8'h02);
        else I_TEMP_BELOW_RESTART <= 1'b1;
        idle();
      end
      wait_run(HC + 12);
      if (!HOLD_K[k]) chk("restart gap", n >= HC, 8'h01);
      I_VO_ZERO <= 1'b0;
      rchk("fault flags", prot_pkg::REG_FLAGS, 8'h3E, 8'h3E);
      idle();
      step(6);
    end
    stop_test();
  end
endmodule : test_converter_protection_manager
`default_nettype wire
